// ### prog_port_pkg.sv
// constants of the serial memory programming port
package prog_port_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned T_WRITE_NS = 3700000;
	localparam int unsigned T_ERASE_NS = 7500000;
	localparam int unsigned WRITE_CYCLES =
		(T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ERASE_CYCLES =
		(T_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FLASH_BYTES = 32768;
	localparam int unsigned EE_BYTES = 1024;
	localparam int unsigned PAGE_BYTES = 128;
	localparam logic [7:0] PE_BYTE1 = 8'hac;
	localparam logic [7:0] PE_BYTE2 = 8'h53;
	localparam logic [2:0] ERASE_B2_TOP = 3'h4;
	localparam logic [3:0] LOAD_B1_TOP = 4'h4;
	localparam logic [3:0] RDFL_B1_TOP = 4'h2;
	localparam logic [2:0] H_B1_LOW = 3'h0;
	localparam logic [7:0] WPAGE_B1 = 8'h4c;
	localparam logic [7:0] RDEE_B1 = 8'ha0;
	localparam logic [7:0] WREE_B1 = 8'hc0;
	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [4:0] LAST_BIT = 5'h1f;
	localparam logic [4:0] THIRD_BYTE_END = 5'h17;
	localparam logic [2:0] BYTE_END = 3'h7;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PAGE = 2'b01,
		ST_EEWR = 2'b10,
		ST_ERASE = 2'b11
	} busy_state_e;
endpackage

// ### pin_sync.sv
// two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_q;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			meta_q <= '0;
			q_o <= '0;
		end
		else if (ce_i)
		begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule

// ### serial_memory_programming_port.sv
// serial in-system programming port with flash and eeprom arrays
`timescale 1ns/1ps
module serial_memory_programming_port #(
	parameter int unsigned WRITE_CYCLES = prog_port_pkg::WRITE_CYCLES,
	parameter int unsigned ERASE_CYCLES = prog_port_pkg::ERASE_CYCLES
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic prog_reset_n_i,
	output logic miso_o,
	output logic write_done_flag_o,
	output logic session_o
);
	// ----------------------------------------------------------
	// pin sampling and edge detection
	// ----------------------------------------------------------
	logic [2:0] pin_s;
	logic sck_q;
	pin_sync #(.WIDTH(3)) u_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.d_i({prog_reset_n_i, mosi_i, sck_i}),
		.q_o(pin_s)
	);
	wire sck_s = pin_s[0];
	wire mosi_s = pin_s[1];
	wire pin_low = ~pin_s[2];
	wire sck_rise = pin_low & sck_s & ~sck_q;
	wire sck_fall = pin_low & ~sck_s & sck_q;

	// ----------------------------------------------------------
	// frame shifter and decode
	// ----------------------------------------------------------
	logic [31:0] frame_q;
	logic [4:0] bit_cnt_q;
	logic [7:0] tx_q;
	logic enabled_q;
	prog_port_pkg::busy_state_e state_q, state_d;
	logic [19:0] cnt_q;
	logic [15:0] idx_q;
	logic [7:0] page_q;
	logic [9:0] ee_addr_q;
	logic [7:0] ee_data_q;
	logic [7:0] flash_mem [prog_port_pkg::FLASH_BYTES];
	logic [7:0] ee_mem [prog_port_pkg::EE_BYTES];
	logic [7:0] pbuf [prog_port_pkg::PAGE_BYTES];

	wire [31:0] frame_nx = {frame_q[30:0], mosi_s};
	wire [7:0] b1 = frame_nx[31:24];
	wire [7:0] b2 = frame_nx[23:16];
	wire [7:0] b3 = frame_nx[15:8];
	wire [7:0] b4 = frame_nx[7:0];
	wire byte_done = sck_rise & (bit_cnt_q[2:0] == prog_port_pkg::BYTE_END);
	wire frame_done = sck_rise & (bit_cnt_q == prog_port_pkg::LAST_BIT);
	wire is_pe = (b1 == prog_port_pkg::PE_BYTE1) &
		(b2 == prog_port_pkg::PE_BYTE2);
	wire is_erase = (b1 == prog_port_pkg::PE_BYTE1) &
		(b2[7:5] == prog_port_pkg::ERASE_B2_TOP);
	wire is_load = (b1[7:4] == prog_port_pkg::LOAD_B1_TOP) &
		(b1[2:0] == prog_port_pkg::H_B1_LOW);
	wire is_wpage = b1 == prog_port_pkg::WPAGE_B1;
	wire is_wree = b1 == prog_port_pkg::WREE_B1;
	wire idle = state_q == prog_port_pkg::ST_IDLE;
	wire cmd_ok = frame_done & enabled_q & idle;
	wire start_page = cmd_ok & is_wpage;
	wire start_ee = cmd_ok & is_wree;
	wire start_erase = cmd_ok & is_erase;
	wire [6:0] pb_idx = {b3[5:0], b1[3]};
	wire [7:0] wp_page = {b2[5:0], b3[7:6]};
	wire [9:0] wr_ee_addr = {b2[1:0], b3};

	// ----------------------------------------------------------
	// read path, loaded after the third byte
	// ----------------------------------------------------------
	wire [7:0] rb1 = frame_nx[23:16];
	wire [7:0] rb2 = frame_nx[15:8];
	wire [7:0] rb3 = frame_nx[7:0];
	wire [14:0] rd_fl_addr = {rb2[5:0], rb3, rb1[3]};
	wire [9:0] rd_ee_addr = {rb2[1:0], rb3};
	wire rd_fl = (rb1[7:4] == prog_port_pkg::RDFL_B1_TOP) &
		(rb1[2:0] == prog_port_pkg::H_B1_LOW);
	wire rd_ee = rb1 == prog_port_pkg::RDEE_B1;
	// page under write polls as ff
	wire fl_hit = (state_q == prog_port_pkg::ST_PAGE) &
		(rd_fl_addr[14:7] == page_q);
	wire ee_hit = (state_q == prog_port_pkg::ST_EEWR) &
		(rd_ee_addr == ee_addr_q);
	wire [7:0] fl_byte = fl_hit ? prog_port_pkg::ERASED : flash_mem[rd_fl_addr];
	wire [7:0] ee_byte = ee_hit ? prog_port_pkg::ERASED : ee_mem[rd_ee_addr];
	wire [7:0] rd_byte = ~enabled_q ? rb3 : rd_fl ? fl_byte :
		rd_ee ? ee_byte : rb3;
	wire third_end = byte_done & (bit_cnt_q == prog_port_pkg::THIRD_BYTE_END);
	// echo previous byte, 53 in sync
	wire [7:0] tx_load = third_end ? rd_byte : frame_nx[7:0];
	wire tx_msb = tx_q[7];

	// ----------------------------------------------------------
	// serial shifting and session
	// ----------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			sck_q <= 1'b0;
			frame_q <= 32'h0;
			bit_cnt_q <= 5'h0;
			tx_q <= 8'h0;
			miso_o <= 1'b0;
			enabled_q <= 1'b0;
			session_o <= 1'b0;
		end
		else if (ce_i)
		begin
			sck_q <= sck_s;
			session_o <= enabled_q & pin_low;
			if (!pin_low)
			begin
				bit_cnt_q <= 5'h0;
				enabled_q <= 1'b0;
			end
			else if (sck_rise)
			begin
				frame_q <= frame_nx;
				bit_cnt_q <= bit_cnt_q + 5'h1;
				if (byte_done)
					tx_q <= tx_load;
				if (frame_done & is_pe)
					enabled_q <= 1'b1;
			end
			else if (sck_fall)
			begin
				miso_o <= tx_msb;
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------
	// busy sequencer
	// ----------------------------------------------------------
	wire cnt_zero = cnt_q == 20'h0;
	wire sweep_on = ((state_q == prog_port_pkg::ST_PAGE) &
		(idx_q < 16'(prog_port_pkg::PAGE_BYTES))) |
		((state_q == prog_port_pkg::ST_ERASE) &
		(idx_q < 16'(prog_port_pkg::FLASH_BYTES)));
	wire [14:0] idx_fl = idx_q[14:0];
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			prog_port_pkg::ST_IDLE:
				if (start_page)
					state_d = prog_port_pkg::ST_PAGE;
				else if (start_ee)
					state_d = prog_port_pkg::ST_EEWR;
				else if (start_erase)
					state_d = prog_port_pkg::ST_ERASE;
			default:
				if (cnt_zero)
					state_d = prog_port_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_q <= prog_port_pkg::ST_IDLE;
			cnt_q <= 20'h0;
			idx_q <= 16'h0;
			page_q <= 8'h0;
			ee_addr_q <= 10'h0;
			ee_data_q <= 8'h0;
			write_done_flag_o <= 1'b1;
		end
		else if (ce_i)
		begin
			state_q <= state_d;
			// busy low one cycle after start
			write_done_flag_o <= state_d == prog_port_pkg::ST_IDLE;
			idx_q <= idle ? 16'h0 : sweep_on ? idx_q + 16'h1 : idx_q;
			if (start_erase)
				cnt_q <= 20'(ERASE_CYCLES - 1);
			else if (start_page | start_ee)
				cnt_q <= 20'(WRITE_CYCLES - 1);
			else if (!idle & !cnt_zero)
				cnt_q <= cnt_q - 20'h1;
			if (start_page)
				page_q <= wp_page;
			if (start_ee)
			begin
				ee_addr_q <= wr_ee_addr;
				ee_data_q <= b4;
			end
		end
	end

	// ----------------------------------------------------------
	// memory arrays
	// ----------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (!reset_i && ce_i)
		begin
			if (cmd_ok & is_load)
				pbuf[pb_idx] <= b4;
			else if (sweep_on & (state_q == prog_port_pkg::ST_PAGE))
			begin
				flash_mem[{page_q, idx_q[6:0]}] <= pbuf[idx_q[6:0]];
				pbuf[idx_q[6:0]] <= prog_port_pkg::ERASED;
			end
			if (sweep_on & (state_q == prog_port_pkg::ST_ERASE))
			begin
				flash_mem[idx_fl] <= prog_port_pkg::ERASED;
				if (idx_q < 16'(prog_port_pkg::EE_BYTES))
					ee_mem[idx_q[9:0]] <= prog_port_pkg::ERASED;
			end
			if (start_ee)
				ee_mem[wr_ee_addr] <= prog_port_pkg::ERASED;
			else if ((state_q == prog_port_pkg::ST_EEWR) & cnt_zero)
				ee_mem[ee_addr_q] <= ee_data_q;
		end
	end

	// ----------------------------------------------------------
	// assertions
	// ----------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);

	AST_PIN_HIGH_ENDS: assert property (
		ce_i && !pin_low |=> !enabled_q ##1 !session_o)
		else $error("session stays open with reset pin high");
	AST_NO_CMD_UNENABLED: assert property (
		ce_i && idle && frame_done && !enabled_q |=> idle)
		else $error("instruction acted before enable");
	AST_EE_SELF_ERASE: assert property (
		state_q == prog_port_pkg::ST_EEWR |-> ee_mem[ee_addr_q] == 8'hff)
		else $error("eeprom location not erased during write");
	AST_ERASE_FF: assert property (
		ce_i && sweep_on && state_q == prog_port_pkg::ST_ERASE
		|=> flash_mem[$past(idx_fl)] == 8'hff)
		else $error("erase left a flash byte not ff");
	AST_SAMPLE_RISE: assert property (
		ce_i && sck_rise |=> frame_q[0] == $past(mosi_s))
		else $error("data-in not sampled on rising edge");
	AST_SHIFT_FALL: assert property (
		ce_i && sck_fall |=> miso_o == $past(tx_msb))
		else $error("data-out not shifted on falling edge");
	AST_ECHO_53: assert property (
		ce_i && byte_done && bit_cnt_q[4:3] == 2'h1 &&
		b4 == prog_port_pkg::PE_BYTE2 |=> tx_q == prog_port_pkg::PE_BYTE2)
		else $error("second enable byte not echoed");
	AST_PAGE_LOAD: assert property (
		ce_i && cmd_ok && is_load |=> pbuf[$past(pb_idx)] == $past(b4))
		else $error("page buffer byte not loaded");
	AST_PAGE_SELECT: assert property (
		ce_i && start_page
		|=> page_q == $past(wp_page) && state_q == prog_port_pkg::ST_PAGE)
		else $error("write page not taken");
	AST_POLL_FF: assert property (
		fl_hit && rd_fl && enabled_q |-> rd_byte == 8'hff)
		else $error("page under write not read as ff");
	AST_BUSY_FLAG: assert property (
		ce_i && (start_page || start_ee || start_erase)
		|=> !write_done_flag_o ##1 !write_done_flag_o)
		else $error("busy flag not asserted after write start");
	AST_FRAME_WRAP: assert property (
		ce_i && frame_done && pin_low |=> bit_cnt_q == 5'h0)
		else $error("frame length not 32 bits");

	COV_ENABLE: cover property (!enabled_q ##1 enabled_q);
	COV_PAGE: cover property (ce_i && start_page);
	COV_EEWR: cover property (ce_i && start_ee);
	COV_ERASE: cover property (ce_i && start_erase);
endmodule

// ### prog_master_model.sv
// programmer model driving the serial programming pins
`timescale 1ns/1ps
module prog_master_model #(
	parameter int unsigned HALF_NS = 80
) (
	input wire logic miso_i,
	output logic sck_o,
	output logic mosi_o,
	output logic prog_reset_n_o
);
	initial
	begin
		sck_o = 1'b0;
		mosi_o = 1'b0;
		prog_reset_n_o = 1'b0;
	end
	// four bytes msb first, always whole
	task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
		int i;
		for (i = 31; i >= 0; i--)
		begin
			mosi_o = tx[i];
			#(HALF_NS);
			sck_o = 1'b1;
			rx[i] = miso_i;
			#(HALF_NS);
			sck_o = 1'b0;
		end
		// idle data line must not look driven
		mosi_o = ~tx[0];
	endtask
	task automatic pulse_reset(input int ns);
		prog_reset_n_o = 1'b1;
		#(ns);
		prog_reset_n_o = 1'b0;
	endtask
endmodule

// ### tb.sv
// self-checking bench of the serial programming port
`timescale 1ns/1ps
module tb;
	localparam int WC = 2000;
	localparam int EC = 33000;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce_i = 1'b1;
	logic sck, mosi, rst_n, miso, done, session;
	int errors = 0;
	int n_compared = 0;
	int seed = 32'h241bf8f8;
	int n, i, w;
	logic [31:0] rx;
	logic [14:0] fa;
	logic [9:0] ea;
	logic [7:0] d, pg;
	logic [7:0] fl_ref [int];
	always #5 clk_i = ~clk_i;
	prog_master_model prog_master_model_inst (.miso_i(miso),
		.sck_o(sck), .mosi_o(mosi), .prog_reset_n_o(rst_n));
	serial_memory_programming_port #(.WRITE_CYCLES(WC),
		.ERASE_CYCLES(EC)) serial_memory_programming_port_inst (
		.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .sck_i(sck),
		.mosi_i(mosi), .prog_reset_n_i(rst_n), .miso_o(miso),
		.write_done_flag_o(done), .session_o(session));
	// ----------------------------------------
	// frames and checks
	// ----------------------------------------
	function automatic logic [31:0] rd_fl(input logic [14:0] a);
		return {4'h2, a[0], 3'h0, 2'h0, a[14:9], a[8:1], 8'h00};
	endfunction
	function automatic logic [31:0] ld(input logic [14:0] a,
		input logic [7:0] v);
		return {4'h4, a[0], 3'h0, 10'h0, a[6:1], v};
	endfunction
	function automatic logic [31:0] rd_ee(input logic [9:0] a);
		return {8'ha0, 6'h0, a, 8'h00};
	endfunction
	function automatic logic [31:0] wr_ee(input logic [9:0] a,
		input logic [7:0] v);
		return {8'hc0, 6'h0, a, v};
	endfunction
	task automatic fr(input logic [31:0] f);
		@(posedge clk_i);
		#1;
		prog_master_model_inst.xfer(f, rx);
	endtask
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check1(input logic got, input logic exp);
		check8({7'h0, got}, {7'h0, exp});
	endtask
	task automatic wait_ready(input int lim, output int cnt);
		cnt = 0;
		while (done !== 1'b1 && cnt < lim)
		begin
			@(posedge clk_i);
			cnt++;
		end
	endtask
	task automatic finish_test;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial
	begin
		#1000000;
		errors++;
		finish_test();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge clk_i);
		#1 reset_i = 1'b0;
		check1(miso, 1'b0);
		check1(done, 1'b1);
		check1(session, 1'b0);
		repeat (8) @(posedge clk_i);
		fr(rd_ee(10'h05));
		check1(session, 1'b0);
		fr({8'hac, 8'h53, 16'h0});
		check8(rx[15:8], 8'h53);
		check1(session, 1'b1);
		fr({8'hac, 8'h80, 16'h0});
		check1(done, 1'b0);
		@(posedge clk_i);
		#1 ce_i = 1'b0;
		repeat (50) @(posedge clk_i);
		#1 check1(done, 1'b0);
		ce_i = 1'b1;
		wait_ready(EC + 100, n);
		check1(n > EC - 20 && n <= EC, 1'b1);
		for (i = 0; i < 4; i++)
		begin
			fa = 15'($random(seed));
			fr(rd_fl(fa));
			check8(rx[7:0], 8'hff);
			fr(rd_ee(fa[9:0]));
			check8(rx[7:0], 8'hff);
		end
		pg = 8'($random(seed));
		for (w = 0; w < 64; w += 21)
			for (i = 0; i < 2; i++)
			begin
				fa = {pg, 6'(w), 1'(i)};
				d = 8'($random(seed));
				fl_ref[fa] = d;
				fr(ld(fa, d));
			end
		fr({8'h4c, 2'h0, pg[7:2], pg[1:0], 14'h0});
		fr(rd_fl({pg, 7'h0}));
		check8(rx[7:0], 8'hff);
		wait_ready(WC, n);
		foreach (fl_ref[k])
		begin
			fr(rd_fl(15'(k)));
			check8(rx[7:0], fl_ref[k]);
		end
		fr(rd_fl({pg + 8'h1, 7'h0}));
		check8(rx[7:0], 8'hff);
		for (i = 0; i < 2; i++)
		begin
			ea = 10'($random(seed));
			d = 8'($random(seed));
			fr(wr_ee(ea, d));
			check1(done, 1'b0);
			fr(rd_ee(ea));
			check8(rx[7:0], 8'hff);
			wait_ready(WC, n);
			check1(n > WC - 600 && n <= WC, 1'b1);
			fr(rd_ee(ea));
			check8(rx[7:0], d);
			fr(wr_ee(ea, ~d));
			wait_ready(WC, n);
			fr(rd_ee(ea));
			check8(rx[7:0], ~d);
		end
		prog_master_model_inst.pulse_reset(200);
		check1(session, 1'b0);
		fr(rd_ee(ea));
		check8(rx[7:0], ea[7:0]);
		finish_test();
	end
endmodule
